// *** hw/imc_pkg.sv ***
// package of timing counts, widths and states for the isa master cycle sequencer
`default_nettype none
package imc_pkg;

    // widths
    localparam int unsigned LA_W   = 7;
    localparam int unsigned SA_W   = 20;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned CNT_W  = 5;
    localparam int unsigned AGE_W  = 6;
    localparam int unsigned IRQ_W  = 4;
    localparam int unsigned DREQ_W = 2;
    localparam int unsigned DACK_W = 3;

    // address field positions
    localparam int unsigned LA_LSB   = 17;
    localparam int unsigned SMEM_LSB = 20;

    // minimum spacings, in periods of the double-rate isa clock
    localparam int unsigned LA_LEAD_ALE_T   = 5;
    localparam int unsigned SA_LEAD_ALE_T   = 1;
    localparam int unsigned SA_LEAD_CMD_T   = 2;
    localparam int unsigned LA_LEAD_CMD_T   = 5;
    localparam int unsigned ALE_WIDTH_T     = 1;
    localparam int unsigned ALE_TO_CMD_T    = 2;
    localparam int unsigned ALE_TO_CMD_END_T = 11;
    localparam int unsigned LA_HOLD_ALE_T   = 14;
    localparam int unsigned LA_HOLD_CMD_T   = 13;
    localparam int unsigned CMD_WIDTH_T     = 9;
    localparam int unsigned SA_HOLD_CMD_T   = 10;

    function automatic int unsigned max2(input int unsigned a, input int unsigned b);
        return (a > b) ? a : b;
    endfunction

    // schedule of a cycle, counted in ticks from the address drive
    localparam int unsigned ALE_ON_N  = max2(LA_LEAD_ALE_T, SA_LEAD_ALE_T) - ALE_WIDTH_T;
    localparam int unsigned ALE_OFF_N = ALE_ON_N + ALE_WIDTH_T;
    localparam int unsigned CMD_ON_N  = max2(max2(ALE_ON_N + ALE_TO_CMD_T, LA_LEAD_CMD_T), SA_LEAD_CMD_T);
    localparam int unsigned CMD_OFF_N = max2(CMD_ON_N + CMD_WIDTH_T, ALE_ON_N + ALE_TO_CMD_END_T);
    localparam int unsigned END_N     = max2(max2(ALE_OFF_N + LA_HOLD_ALE_T, CMD_ON_N + LA_HOLD_CMD_T),
                                             max2(CMD_ON_N + SA_HOLD_CMD_T, CMD_OFF_N));

    localparam logic [CNT_W-1:0] ALE_ON_C  = CNT_W'(ALE_ON_N);
    localparam logic [CNT_W-1:0] ALE_OFF_C = CNT_W'(ALE_OFF_N);
    localparam logic [CNT_W-1:0] CMD_ON_C  = CNT_W'(CMD_ON_N);
    localparam logic [CNT_W-1:0] CMD_OFF_C = CNT_W'(CMD_OFF_N);
    localparam logic [CNT_W-1:0] END_C     = CNT_W'(END_N);

    // reset value of the ages, and the address page that selects the low-memory strobes
    localparam logic [AGE_W-1:0] AGE_MAX   = 6'h3f;
    localparam logic [3:0]       SMEM_PAGE = 4'h0;

    typedef enum logic [2:0] {
        IMC_IDLE  = 3'b000,
        IMC_LEAD  = 3'b001,
        IMC_ALE   = 3'b010,
        IMC_SETUP = 3'b011,
        IMC_CMD   = 3'b100,
        IMC_HOLD  = 3'b101
    } imc_state_t;

endpackage
`default_nettype wire

// *** hw/imc_sync.sv ***
// two-flop synchroniser for levels arriving from outside the clk domain
`default_nettype none
module imc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] dout_reg;
    logic [WIDTH-1:0] dout_next;

    always_comb begin
        meta_next = ce ? din : meta_reg;
        dout_next = ce ? meta_reg : dout_reg;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            dout_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            dout_reg <= dout_next;
        end
    end

    assign dout = dout_reg;

endmodule
`default_nettype wire

// *** hw/imc_req_sampler.sv ***
// captures the muxed interrupt and dma request lines on each rising edge of the double-rate clock
`default_nettype none
module imc_req_sampler (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic                        tick,
    // synchronised request lines
    input  wire logic [imc_pkg::IRQ_W-1:0]   irq_in,
    input  wire logic [imc_pkg::DREQ_W-1:0]  dreq_in,
    // sampled values
    output logic      [imc_pkg::IRQ_W-1:0]   irq_out,
    output logic      [imc_pkg::DREQ_W-1:0]  dreq_out
);

    logic [imc_pkg::IRQ_W-1:0]  irq_reg;
    logic [imc_pkg::IRQ_W-1:0]  irq_next;
    logic [imc_pkg::DREQ_W-1:0] dreq_reg;
    logic [imc_pkg::DREQ_W-1:0] dreq_next;

    always_comb begin
        irq_next  = irq_reg;
        dreq_next = dreq_reg;
        if (ce && tick) begin
            irq_next  = irq_in;
            dreq_next = dreq_in;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg  <= '0;
            dreq_reg <= '0;
        end else begin
            irq_reg  <= irq_next;
            dreq_reg <= dreq_next;
        end
    end

    assign irq_out  = irq_reg;
    assign dreq_out = dreq_reg;

endmodule
`default_nettype wire

// *** hw/imc_master.sv ***
// isa master cycle sequencer timed in periods of the double-rate isa clock
//
// Overview of operation
// - the latchable upper address is valid at least 5T before the address latch enable falls.
// - the latchable upper address is valid at least 5T before a memory strobe asserts.
// - system address and byte-high enable are valid at least 1T before the latch enable falls.
// - system address and byte-high enable are valid at least 2T before any command strobe asserts.
// - the address latch enable stays high for at least 1T.
// - a command strobe asserts no earlier than 2T after the latch enable rises.
// - a memory strobe negates no earlier than 11T after the latch enable rises.
// - the latchable upper address holds for at least 14T after the latch enable falls.
// - the latchable upper address holds for at least 13T after a memory strobe asserts.
// - every command strobe stays asserted for at least 9T.
// - the system address holds for at least 10T after a command strobe asserts.
// - the encoded dma acknowledge is driven from the double-rate clock.
`default_nettype none
module imc_master (
    // clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    // link clock and muxed requests from outside
    input  wire logic                        isa_double_rate_clock,
    input  wire logic [imc_pkg::IRQ_W-1:0]   muxed_interrupt_requests,
    input  wire logic [imc_pkg::DREQ_W-1:0]  muxed_dma_requests,
    // cycle request port
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic                        req_io,
    input  wire logic [imc_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic                        req_byte_high,
    output logic                             req_ready,
    output logic                             cyc_done,
    // dma acknowledge source
    input  wire logic [imc_pkg::DACK_W-1:0]  dack_code_in,
    input  wire logic                        tc_in,
    // isa bus pins
    output logic                             isa_bus_clk,
    output logic                             bus_oe,
    output logic [imc_pkg::LA_W-1:0]         la_out,
    output logic [imc_pkg::SA_W-1:0]         sa_out,
    output logic                             sbhe_n,
    output logic                             addr_latch_en,
    output logic                             memr_n,
    output logic                             memw_n,
    output logic                             smemr_n,
    output logic                             smemw_n,
    output logic                             ior_n,
    output logic                             iow_n,
    output logic [imc_pkg::DACK_W-1:0]       encoded_dma_acknowledge,
    output logic                             tc_out,
    // sampled requests
    output logic [imc_pkg::IRQ_W-1:0]        irq_sampled,
    output logic [imc_pkg::DREQ_W-1:0]       dreq_sampled
);

    ////////////////////////////////////////////////////////////////////////////
    // link clock sampling and edge detection

    logic                       dclk_sync;
    logic [imc_pkg::IRQ_W-1:0]  irq_sync;
    logic [imc_pkg::DREQ_W-1:0] dreq_sync;
    logic                       dclk_prev_reg;
    logic                       dclk_prev_next;
    logic                       tick;

    imc_sync #(.WIDTH(1 + imc_pkg::IRQ_W + imc_pkg::DREQ_W)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .din  ({isa_double_rate_clock, muxed_interrupt_requests, muxed_dma_requests}),
        .dout ({dclk_sync, irq_sync, dreq_sync})
    );

    // one tick per rising edge of the double-rate clock
    assign tick = dclk_sync & ~dclk_prev_reg;

    // requests are sampled where the external mux presents them
    imc_req_sampler u_sampler (
        .clk      (clk),
        .nrst     (nrst),
        .ce       (ce),
        .tick     (tick),
        .irq_in   (irq_sync),
        .dreq_in  (dreq_sync),
        .irq_out  (irq_sampled),
        .dreq_out (dreq_sampled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // cycle sequencer

    imc_pkg::imc_state_t          state_reg, state_next;
    logic [imc_pkg::CNT_W-1:0]    cnt_reg, cnt_next;
    logic [imc_pkg::CNT_W-1:0]    cnt_inc;
    logic                         write_reg, write_next;
    logic                         io_reg, io_next;
    logic                         smem_reg, smem_next;
    logic [imc_pkg::LA_W-1:0]     la_reg, la_next;
    logic [imc_pkg::SA_W-1:0]     sa_reg, sa_next;
    logic                         sbhe_n_reg, sbhe_n_next;
    logic                         ale_reg, ale_next;
    logic                         cmd_reg, cmd_next;
    logic                         oe_reg, oe_next;
    logic                         ready_reg, ready_next;
    logic                         done_reg, done_next;
    logic                         bclk_reg, bclk_next;
    logic [imc_pkg::DACK_W-1:0]   dack_reg, dack_next;
    logic                         tc_reg, tc_next;
    assign cnt_inc = cnt_reg + 5'h01;
    always_comb begin
        dclk_prev_next = ce ? dclk_sync : dclk_prev_reg;
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        write_next  = write_reg;
        io_next     = io_reg;
        smem_next   = smem_reg;
        la_next     = la_reg;
        sa_next     = sa_reg;
        sbhe_n_next = sbhe_n_reg;
        ale_next    = ale_reg;
        cmd_next    = cmd_reg;
        oe_next     = oe_reg;
        ready_next  = ready_reg;
        done_next   = 1'b0;
        bclk_next   = bclk_reg;
        dack_next   = dack_reg;
        tc_next     = tc_reg;
        if (ce && tick) begin
            bclk_next = ~bclk_reg;
            dack_next = dack_code_in;
            tc_next   = tc_in;
            cnt_next  = cnt_inc;
            case (state_reg)
                imc_pkg::IMC_IDLE: begin
                    cnt_next = '0;
                    if (req_valid) begin
                        // address and byte enable driven together at count zero
                        la_next     = req_addr[imc_pkg::LA_LSB +: imc_pkg::LA_W];
                        sa_next     = req_addr[imc_pkg::SA_W-1:0];
                        sbhe_n_next = ~req_byte_high;
                        write_next  = req_write;
                        io_next     = req_io;
                        smem_next   = req_addr[imc_pkg::ADDR_W-1:imc_pkg::SMEM_LSB] == imc_pkg::SMEM_PAGE;
                        oe_next     = 1'b1;
                        ready_next  = 1'b0;
                        state_next  = imc_pkg::IMC_LEAD;
                    end
                end
                imc_pkg::IMC_LEAD: begin
                    if (cnt_inc == imc_pkg::ALE_ON_C) begin
                        ale_next   = 1'b1;
                        state_next = imc_pkg::IMC_ALE;
                    end
                end
                imc_pkg::IMC_ALE: begin
                    if (cnt_inc == imc_pkg::ALE_OFF_C) begin
                        ale_next   = 1'b0;
                        state_next = imc_pkg::IMC_SETUP;
                    end
                end
                imc_pkg::IMC_SETUP: begin
                    if (cnt_inc == imc_pkg::CMD_ON_C) begin
                        cmd_next   = 1'b1;
                        state_next = imc_pkg::IMC_CMD;
                    end
                end
                imc_pkg::IMC_CMD: begin
                    if (cnt_inc == imc_pkg::CMD_OFF_C) begin
                        cmd_next   = 1'b0;
                        state_next = imc_pkg::IMC_HOLD;
                    end
                end
                imc_pkg::IMC_HOLD: begin
                    // addresses held until the longest hold has passed
                    if (cnt_inc == imc_pkg::END_C) begin
                        oe_next    = 1'b0;
                        ready_next = 1'b1;
                        done_next  = 1'b1;
                        state_next = imc_pkg::IMC_IDLE;
                    end
                end
                default: begin
                    ale_next   = 1'b0;
                    cmd_next   = 1'b0;
                    oe_next    = 1'b0;
                    ready_next = 1'b1;
                    state_next = imc_pkg::IMC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dclk_prev_reg <= 1'b0;
            state_reg  <= imc_pkg::IMC_IDLE;
            cnt_reg    <= '0;
            write_reg  <= 1'b0;
            io_reg     <= 1'b0;
            smem_reg   <= 1'b0;
            la_reg     <= '0;
            sa_reg     <= '0;
            sbhe_n_reg <= 1'b1;
            ale_reg    <= 1'b0;
            cmd_reg    <= 1'b0;
            oe_reg     <= 1'b0;
            ready_reg  <= 1'b1;
            done_reg   <= 1'b0;
            bclk_reg   <= 1'b0;
            dack_reg   <= '0;
            tc_reg     <= 1'b0;
        end else begin
            dclk_prev_reg <= dclk_prev_next;
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            write_reg  <= write_next;
            io_reg     <= io_next;
            smem_reg   <= smem_next;
            la_reg     <= la_next;
            sa_reg     <= sa_next;
            sbhe_n_reg <= sbhe_n_next;
            ale_reg    <= ale_next;
            cmd_reg    <= cmd_next;
            oe_reg     <= oe_next;
            ready_reg  <= ready_next;
            done_reg   <= done_next;
            bclk_reg   <= bclk_next;
            dack_reg   <= dack_next;
            tc_reg     <= tc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobe decode, registered so pins come straight from flops

    logic [5:0] strb_n_reg;
    logic [5:0] strb_n_next;

    always_comb begin
        strb_n_next[5] = ~(cmd_next & ~io_next & ~write_next);
        strb_n_next[4] = ~(cmd_next & ~io_next & write_next);
        strb_n_next[3] = ~(cmd_next & ~io_next & ~write_next & smem_next);
        strb_n_next[2] = ~(cmd_next & ~io_next & write_next & smem_next);
        strb_n_next[1] = ~(cmd_next & io_next & ~write_next);
        strb_n_next[0] = ~(cmd_next & io_next & write_next);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strb_n_reg <= '1;
        end else begin
            strb_n_reg <= strb_n_next;
        end
    end

    assign req_ready               = ready_reg;
    assign cyc_done                = done_reg;
    assign isa_bus_clk             = bclk_reg;
    assign bus_oe                  = oe_reg;
    assign la_out                  = la_reg;
    assign sa_out                  = sa_reg;
    assign sbhe_n                  = sbhe_n_reg;
    assign addr_latch_en           = ale_reg;
    assign memr_n                  = strb_n_reg[5];
    assign memw_n                  = strb_n_reg[4];
    assign smemr_n                 = strb_n_reg[3];
    assign smemw_n                 = strb_n_reg[2];
    assign ior_n                   = strb_n_reg[1];
    assign iow_n                   = strb_n_reg[0];
    assign encoded_dma_acknowledge = dack_reg;
    assign tc_out                  = tc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks: ages in ticks since each bus event

    logic                      strobe_on;
    logic                      mem_on;
    logic [imc_pkg::AGE_W-1:0] la_age, sa_age, ale_age, ale_off_age, cmd_age;

    assign strobe_on = ~&strb_n_reg;
    assign mem_on    = ~&strb_n_reg[5:4];

    function automatic logic [imc_pkg::AGE_W-1:0] age_step(input logic [imc_pkg::AGE_W-1:0] a);
        return (a == imc_pkg::AGE_MAX) ? a : a + 6'h01;
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            la_age      <= imc_pkg::AGE_MAX;
            sa_age      <= imc_pkg::AGE_MAX;
            ale_age     <= imc_pkg::AGE_MAX;
            ale_off_age <= imc_pkg::AGE_MAX;
            cmd_age     <= imc_pkg::AGE_MAX;
        end else if (ce && tick) begin
            la_age      <= (la_next != la_reg || (oe_next && !oe_reg)) ? '0 : age_step(la_age);
            sa_age      <= (sa_next != sa_reg || sbhe_n_next != sbhe_n_reg || (oe_next && !oe_reg))
                           ? '0 : age_step(sa_age);
            ale_age     <= (ale_next && !ale_reg) ? '0 : age_step(ale_age);
            ale_off_age <= (!ale_next && ale_reg) ? '0 : age_step(ale_off_age);
            cmd_age     <= (cmd_next && !cmd_reg) ? '0 : age_step(cmd_age);
        end
    end

    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_la_before_ale: assert property ($fell(ale_reg) |-> la_age >= imc_pkg::LA_LEAD_ALE_T)
        else $error("upper address not valid 5T before latch enable fell");
    a_la_before_mem: assert property ($rose(mem_on) |-> la_age >= imc_pkg::LA_LEAD_CMD_T)
        else $error("upper address not valid 5T before memory strobe");
    a_sa_before_ale: assert property ($fell(ale_reg) |-> sa_age >= imc_pkg::SA_LEAD_ALE_T)
        else $error("system address not valid 1T before latch enable fell");
    a_sa_before_cmd: assert property ($rose(strobe_on) |-> sa_age >= imc_pkg::SA_LEAD_CMD_T)
        else $error("system address not valid 2T before strobe");
    a_ale_width: assert property ($rose(ale_reg) |=> ale_reg [*4])
        else $error("latch enable pulse too short");
    a_ale_to_cmd: assert property ($rose(strobe_on) |-> ale_age >= imc_pkg::ALE_TO_CMD_T)
        else $error("strobe less than 2T after latch enable");
    a_ale_to_mem_end: assert property ($fell(mem_on) |-> ale_age >= imc_pkg::ALE_TO_CMD_END_T)
        else $error("memory strobe ended before 11T from latch enable");
    a_la_hold_ale: assert property ($changed({la_reg, oe_reg}) |-> ale_off_age >= imc_pkg::LA_HOLD_ALE_T)
        else $error("upper address changed within 14T of latch enable fall");
    a_la_hold_mem: assert property ($changed({la_reg, oe_reg}) |-> cmd_age >= imc_pkg::LA_HOLD_CMD_T)
        else $error("upper address changed within 13T of strobe");
    a_cmd_width: assert property ($fell(strobe_on) |-> cmd_age >= imc_pkg::CMD_WIDTH_T)
        else $error("strobe shorter than 9T");
    a_sa_hold_cmd: assert property ($changed({sa_reg, oe_reg}) |-> cmd_age >= imc_pkg::SA_HOLD_CMD_T)
        else $error("system address changed within 10T of strobe");
    a_dack_on_edge: assert property ($changed(dack_reg) |-> $past(tick) && $past(ce))
        else $error("dma acknowledge changed off the double-rate clock edge");
    a_bclk_half_rate: assert property ($changed(bclk_reg) |-> $past(tick) && $past(ce))
        else $error("bus clock toggled off the double-rate clock edge");

endmodule
`default_nettype wire

// *** bench/imc_far_model.sv ***
// free-running double-rate link clock and interrupt/dma request mux at the far side
`default_nettype none
module imc_far_model (
    // link side
    output var logic                       link_clk,
    output var logic [imc_pkg::IRQ_W-1:0]  irq_mux,
    output var logic [imc_pkg::DREQ_W-1:0] dreq_mux
);
    timeunit 1ns;
    timeprecision 1ns;
    // values move on the falling edge, so they sit still around each rising edge
    initial begin
        link_clk = 1'b0;
        irq_mux = 4'h0;
        dreq_mux = 2'h0;
        #3;
        forever begin
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
            irq_mux = irq_mux + 4'h3;
            dreq_mux = dreq_mux + 2'h1;
        end
    end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the isa master cycle sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic             req_valid = 1'b0;
    logic             req_write = 1'b0;
    logic             req_io = 1'b0;
    logic             req_byte_high = 1'b0;
    logic             tc_in = 1'b0;
    logic [23:0]      req_addr = 24'h0;
    logic [2:0]       dack_code_in = 3'h0;
    wire logic        link_clk, req_ready, cyc_done, bus_clk, bus_oe, sbhe_n, ale, tc_out;
    wire logic [6:0]  la;
    wire logic [19:0] sa;
    wire logic [2:0]  dack;
    wire logic [3:0]  irq_mux, irq_s;
    wire logic [1:0]  dreq_mux, dreq_s;
    wire logic [5:0]  strb;
    wire logic [8:0]  st = {req_ready, cyc_done, ale, strb};
    int               n_errors = 0;
    int               n_compared = 0;
    always #4 clk = ~clk;
    imc_far_model u_far (.link_clk(link_clk), .irq_mux(irq_mux), .dreq_mux(dreq_mux));
    imc_master u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .isa_double_rate_clock(link_clk),
        .muxed_interrupt_requests(irq_mux), .muxed_dma_requests(dreq_mux), .req_valid(req_valid),
        .req_write(req_write), .req_io(req_io), .req_addr(req_addr), .req_byte_high(req_byte_high),
        .req_ready(req_ready), .cyc_done(cyc_done), .dack_code_in(dack_code_in), .tc_in(tc_in),
        .isa_bus_clk(bus_clk), .bus_oe(bus_oe), .la_out(la), .sa_out(sa), .sbhe_n(sbhe_n),
        .addr_latch_en(ale), .memr_n(strb[5]), .memw_n(strb[4]), .smemr_n(strb[3]), .smemw_n(strb[2]),
        .ior_n(strb[1]), .iow_n(strb[0]), .encoded_dma_acknowledge(dack), .tc_out(tc_out),
        .irq_sampled(irq_s), .dreq_sampled(dreq_s));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // waits for the next change of a status word, then checks the spacing and the new value
    task automatic wait_change(input logic [8:0] exp, input int gap, input logic [8:0] prev);
        int n;
        n = 0;
        while (st === prev && n < 400) begin
            step(1);
            n++;
        end
        if (n == 400) begin
            n_errors++;
            close_out();
        end else begin
            if (gap >= 0)
                check(n, gap);
            check(st, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_cycle(input logic wr, input logic io, input logic [23:0] a, input logic bh);
        logic       lo;
        logic [5:0] p;
        logic [27:0] adr;
        lo = ~io & (a[23:20] == 4'h0);
        p = ~{~io & ~wr, ~io & wr, lo & ~wr, lo & wr, io & ~wr, io & wr};
        adr = {a[23:17], a[19:0], ~bh};
        @(posedge clk);
        {req_write, req_io, req_addr, req_byte_high, req_valid} <= {wr, io, a, bh, 1'b1};
        wait_change(9'h03f, -1, st);
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        // one clk of the lead already spent releasing the request
        wait_change(9'h07f, 79, st);
        check({la, sa, sbhe_n, bus_oe}, {adr, 1'b1});
        wait_change(9'h03f, 20, st);
        wait_change({3'h0, p}, 20, st);
        wait_change(9'h03f, 180, st);
        check({la, sa, sbhe_n}, adr);
        wait_change(9'h1bf, 80, st);
        check(bus_oe, 1'b0);
        wait_change(9'h13f, 1, st);
    endtask
    task automatic sample_check(input logic [2:0] d, input logic t);
        int n;
        @(posedge clk);
        dack_code_in <= d;
        tc_in <= t;
        step(1);
        n = 0;
        while (n < 2) begin
            wait_change_tog(n);
        end
    endtask
    task automatic wait_change_tog(inout int k);
        logic b;
        int   n;
        b = bus_clk;
        n = 0;
        while (bus_clk === b && n < 40) begin
            step(1);
            n++;
        end
        if (n == 40) begin
            n_errors++;
            close_out();
        end else begin
            if (k == 1)
                check(n, 20);
            check({irq_s, dreq_s, dack, tc_out}, {irq_mux, dreq_mux, dack_code_in, tc_in});
            k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        step(1);
        check({st, bus_oe}, {9'h13f, 1'b0});
        run_cycle(1'b0, 1'b0, 24'h0a5432, 1'b1);
        run_cycle(1'b1, 1'b0, 24'h9e0011, 1'b0);
        run_cycle(1'b0, 1'b1, 24'h0003f8, 1'b1);
        run_cycle(1'b1, 1'b1, 24'hfffffe, 1'b0);
        run_cycle(1'b1, 1'b0, 24'h0e0011, 1'b1);
        run_cycle(1'b0, 1'b0, 24'h7ffffe, 1'b0);
        sample_check(3'h5, 1'b1);
        sample_check(3'h2, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
